// ===== verilog/bsas_params.svh
`ifndef BSAS_PARAMS_SVH
`define BSAS_PARAMS_SVH
`define BSAS_FABRIC_CELLS 64
`define BSAS_CELLS_PER_SEL 16
`define BSAS_NUM_SEL (`BSAS_FABRIC_CELLS / `BSAS_CELLS_PER_SEL)
`define BSAS_MAX_DC_BITS 24
// Register map, byte addresses
`define BSAS_GCTRL_ADDR 12'h000
`define BSAS_GSTAT_ADDR 12'h004
`define BSAS_SEL_PAGE 4'h1
`define BSAS_SEL_ZMASK_OFS 4'h0
`define BSAS_SEL_OMASK_OFS 4'h4
`define BSAS_SEL_CTRL_OFS 4'h8
`define BSAS_SEL_STAT_OFS 4'hc
// Selector control fields
`define BSAS_CTRL_MODE_LSB 0
`define BSAS_CTRL_DATA_BIT 2
`define BSAS_CTRL_SPEC_BIT 3
`define BSAS_CTRL_WAIT_BIT 4
// DMA control byte fields (each kept in both nibbles)
`define BSAS_DMA_ENBL_BIT 0
`define BSAS_DMA_CHAN_BIT 1
`define BSAS_MASK_RESET 32'h0000_0000
`define BSAS_CTRL_RESET 5'h00
`endif

// ===== verilog/bsas_pkg.sv
package bsas_pkg;
	typedef enum logic [1:0] {BSAS_MODE_PLAIN, BSAS_MODE_COMBINED_DECODE_MACRO, BSAS_MODE_DMA, BSAS_MODE_EXTPORT}
		bsas_mode_t;
	// One system bus request as seen by the socket
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic space_spec;
	} bsas_req_t;
	// Per-selector configuration
	typedef struct packed {
		logic init_wait;
		logic space_spec;
		logic space_data;
		bsas_mode_t mode;
	} bsas_cfg_t;
endpackage : bsas_pkg

// ===== verilog/bsas_socket.sv
`timescale 1ns/1ns
`include "bsas_params.svh"
module bsas_socket
	import bsas_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire bsas_req_t BUS_REQ_IN,
	output logic [7:0] BUS_RDATA_OUT,
	output logic BUS_WAIT_OUT,
	input wire logic [`BSAS_NUM_SEL*8-1:0] FABRIC_RDATA_IN,
	input wire logic EXTEND_NEXT_CYCLE_IN,
	output logic WAIT_HISTORY_FLAG_OUT,
	output logic [31:0] FABRIC_ADDR_OUT,
	output logic [7:0] FABRIC_WDATA_OUT,
	output logic [`BSAS_NUM_SEL-1:0] READ_STROBE_OUT,
	output logic [`BSAS_NUM_SEL-1:0] WRITE_STROBE_OUT,
	output logic [`BSAS_NUM_SEL-1:0] DEVICE_ENABLE_OUT,
	output logic [`BSAS_NUM_SEL-1:0] EXT_PORT_TAKE_OUT,
	input wire logic [`BSAS_NUM_SEL-1:0] DMA_REQUEST_IN,
	output logic [`BSAS_NUM_SEL-1:0] DMA_GRANT_OUT,
	output logic [1:0] DMA_CHAN_REQ_OUT,
	input wire logic [1:0] DMA_CHAN_ACK_IN
);
	localparam int NSEL = `BSAS_NUM_SEL;

	logic [31:0] zmask_q [NSEL];
	logic [31:0] omask_q [NSEL];
	bsas_cfg_t cfg_q [NSEL];
	logic [1:0] dmactl_q [NSEL];
	logic lock_q;
	logic active_q;
	logic wait_q;
	logic hist_q;
	logic [NSEL-1:0] rd_q, wr_q, en_q, ext_q, dmard_q, grant_q;
	logic [7:0] rdata_q;
	logic [31:0] addr_q;
	logic [7:0] wdata_q;
	logic [1:0] chreq_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [NSEL-1:0] hit;
	logic [NSEL-1:0] cfg_ok;
	logic hold, take, init_hit;
	logic [7:0] rdata_d;
	logic [1:0] chreq_d;
	logic [NSEL-1:0] dma_on, grant_d;
	logic [1:0] apb_sel;
	logic apb_err;
	logic [31:0] apb_rv;

	// Per-bit compare: a bit in neither mask can never match
	function automatic logic addr_match(input logic [31:0] a, input logic [31:0] z,
		input logic [31:0] o);
		addr_match = &((z & ~a) | (o & a));
	endfunction : addr_match

	// Don't-care bits must form a low-order run no longer than the 16M limit
	function automatic logic range_ok(input logic [31:0] z, input logic [31:0] o);
		logic [31:0] dc;
		dc = z & o;
		range_ok = ((dc & (dc + 32'h0000_0001)) == 32'h0000_0000) &&
			(dc[31:`BSAS_MAX_DC_BITS] == '0);
	endfunction : range_ok

	// A held transaction blocks new requests; the master keeps its request up meanwhile
	assign hold = active_q && wait_q;
	assign take = !hold && (BUS_REQ_IN.rd || BUS_REQ_IN.wr);

	// Address and space decode for every selector
	always_comb
	begin
		init_hit = 1'b0;
		for (int i = 0; i < NSEL; i++)
		begin
			cfg_ok[i] = range_ok(zmask_q[i], omask_q[i]);
			hit[i] = cfg_ok[i] && addr_match(BUS_REQ_IN.addr, zmask_q[i], omask_q[i]) &&
				(BUS_REQ_IN.space_spec ? cfg_q[i].space_spec : cfg_q[i].space_data);
			init_hit = init_hit | (hit[i] & cfg_q[i].init_wait);
		end
	end

	// Registered strobes appear with the registered address and write data
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			rd_q <= '0;
			wr_q <= '0;
			en_q <= '0;
			ext_q <= '0;
			dmard_q <= '0;
		end
		else if (take)
		begin
			for (int i = 0; i < NSEL; i++)
			begin
				rd_q[i] <= hit[i] && BUS_REQ_IN.rd && (cfg_q[i].mode == BSAS_MODE_PLAIN ||
					cfg_q[i].mode == BSAS_MODE_COMBINED_DECODE_MACRO);
				wr_q[i] <= hit[i] && BUS_REQ_IN.wr &&
					cfg_q[i].mode == BSAS_MODE_PLAIN;
				en_q[i] <= hit[i] && cfg_q[i].mode == BSAS_MODE_COMBINED_DECODE_MACRO;
				ext_q[i] <= hit[i] && cfg_q[i].mode == BSAS_MODE_EXTPORT;
				dmard_q[i] <= hit[i] && BUS_REQ_IN.rd && cfg_q[i].mode == BSAS_MODE_DMA;
			end
		end
		else if (!hold)
		begin
			// Idle cycle or finished transaction: nothing stays selected
			rd_q <= '0;
			wr_q <= '0;
			en_q <= '0;
			ext_q <= '0;
			dmard_q <= '0;
		end
	end

	// Address and write data go to the fabric unchanged and in full width
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			addr_q <= 32'h0000_0000;
			wdata_q <= 8'h00;
		end
		else if (take)
		begin
			addr_q <= BUS_REQ_IN.addr;
			wdata_q <= BUS_REQ_IN.wdata;
		end
	end

	// Transaction and wait tracking; the selector's first wait covers reads and writes alike
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			active_q <= 1'b0;
			wait_q <= 1'b0;
			hist_q <= 1'b0;
		end
		else
		begin
			active_q <= take || hold;
			wait_q <= (take && init_hit) ||
				(active_q && EXTEND_NEXT_CYCLE_IN);
			hist_q <= wait_q;
		end
	end

	// Read data is a plain OR of every contribution plus any DMA control byte read
	always_comb
	begin
		rdata_d = 8'h00;
		for (int i = 0; i < NSEL; i++)
		begin
			rdata_d = rdata_d | FABRIC_RDATA_IN[i*8 +: 8];
			if (dmard_q[i])
				rdata_d = rdata_d | {2'b00, dmactl_q[i], 2'b00, dmactl_q[i]};
		end
	end

	// Costs one cycle of latency but keeps the output registered
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	// DMA control byte written through its own decoded address, both nibbles ORed
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			for (int i = 0; i < NSEL; i++)
				dmactl_q[i] <= 2'b00;
		end
		else if (take && BUS_REQ_IN.wr)
		begin
			for (int i = 0; i < NSEL; i++)
				if (hit[i] && cfg_q[i].mode == BSAS_MODE_DMA)
					dmactl_q[i] <= BUS_REQ_IN.wdata[5:4] | BUS_REQ_IN.wdata[1:0];
		end
	end

	// Request gating and steering to a channel, grant steered back
	always_comb
	begin
		chreq_d = 2'b00;
		dma_on = '0;
		grant_d = '0;
		for (int i = 0; i < NSEL; i++)
		begin
			dma_on[i] = cfg_q[i].mode == BSAS_MODE_DMA && dmactl_q[i][`BSAS_DMA_ENBL_BIT];
			if (dma_on[i] && DMA_REQUEST_IN[i])
				chreq_d[dmactl_q[i][`BSAS_DMA_CHAN_BIT]] = 1'b1;
			grant_d[i] = dma_on[i] && DMA_CHAN_ACK_IN[dmactl_q[i][`BSAS_DMA_CHAN_BIT]];
		end
	end

	// Channel request and grant leave flip-flops, one cycle after their inputs
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			chreq_q <= 2'b00;
			grant_q <= '0;
		end
		else
		begin
			chreq_q <= chreq_d;
			grant_q <= grant_d;
		end
	end

	// Four selectors need two index bits; the index check against NSEL keeps higher indices out
	assign apb_sel = PADDR_IN[5:4];

	// Register decode shared by the read data and the error response
	always_comb
	begin
		apb_err = 1'b0;
		apb_rv = 32'h0000_0000;
		if (PADDR_IN == `BSAS_GCTRL_ADDR)
			apb_rv = {31'h0, lock_q};
		else if (PADDR_IN == `BSAS_GSTAT_ADDR)
			apb_rv = {29'h0, hist_q, wait_q, active_q};
		else if (PADDR_IN[11:8] == `BSAS_SEL_PAGE && 32'(PADDR_IN[7:4]) < NSEL)
		begin
			unique case (PADDR_IN[3:0])
				`BSAS_SEL_ZMASK_OFS: apb_rv = zmask_q[apb_sel];
				`BSAS_SEL_OMASK_OFS: apb_rv = omask_q[apb_sel];
				`BSAS_SEL_CTRL_OFS: apb_rv = {27'h0, cfg_q[apb_sel]};
				`BSAS_SEL_STAT_OFS: apb_rv = {29'h0, dmactl_q[apb_sel], cfg_ok[apb_sel]};
				default: apb_err = 1'b1;
			endcase
			// Masks are frozen once initialization is declared finished
			if (PWRITE_IN && lock_q && PADDR_IN[3] == 1'b0)
				apb_err = 1'b1;
		end
		else
			apb_err = 1'b1;
	end

	// APB slave: one wait cycle so that read data leaves a flip-flop
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= PSEL_IN && PENABLE_IN && !pready_q;
			pslverr_q <= PSEL_IN && PENABLE_IN && !pready_q && apb_err;
			prdata_q <= (PSEL_IN && !PWRITE_IN && !apb_err) ? apb_rv : 32'h0000_0000;
		end
	end

	// Configuration writes land on the edge where pready is sampled
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			lock_q <= 1'b0;
			for (int i = 0; i < NSEL; i++)
			begin
				zmask_q[i] <= `BSAS_MASK_RESET;
				omask_q[i] <= `BSAS_MASK_RESET;
				cfg_q[i] <= `BSAS_CTRL_RESET;
			end
		end
		else if (PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN && !pslverr_q)
		begin
			if (PADDR_IN == `BSAS_GCTRL_ADDR && PWDATA_IN[0])
				lock_q <= 1'b1;
			if (PADDR_IN[11:8] == `BSAS_SEL_PAGE)
			begin
				unique case (PADDR_IN[3:0])
					`BSAS_SEL_ZMASK_OFS: zmask_q[apb_sel] <= PWDATA_IN;
					`BSAS_SEL_OMASK_OFS: omask_q[apb_sel] <= PWDATA_IN;
					`BSAS_SEL_CTRL_OFS: cfg_q[apb_sel] <= bsas_cfg_t'(PWDATA_IN[4:0]);
					default: ;
				endcase
			end
		end
	end

	// Outputs come straight from the registers above
	assign PRDATA_OUT = prdata_q;
	assign PREADY_OUT = pready_q;
	assign PSLVERR_OUT = pslverr_q;
	assign BUS_RDATA_OUT = rdata_q;
	assign BUS_WAIT_OUT = wait_q;
	assign WAIT_HISTORY_FLAG_OUT = hist_q;
	assign FABRIC_ADDR_OUT = addr_q;
	assign FABRIC_WDATA_OUT = wdata_q;
	assign READ_STROBE_OUT = rd_q;
	assign WRITE_STROBE_OUT = wr_q;
	assign DEVICE_ENABLE_OUT = en_q;
	assign EXT_PORT_TAKE_OUT = ext_q;
	assign DMA_GRANT_OUT = grant_q;
	assign DMA_CHAN_REQ_OUT = chreq_q;

	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	sequence s_sel_wait_req;
		take && init_hit;
	endsequence

	sequence s_wait_history_flag_cycle;
		wait_q ##1 hist_q;
	endsequence

	a_history_one_late: assert property (wait_q |=> hist_q)
		else $error("wait history missed a wait-state");
	a_history_no_false: assert property (!wait_q |=> !hist_q)
		else $error("wait history without a wait-state");
	a_first_wait_sel: assert property (s_sel_wait_req |=> wait_q && active_q)
		else $error("selector first wait missing");
	a_extend_next_wait: assert property (active_q && EXTEND_NEXT_CYCLE_IN |=> wait_q)
		else $error("extend input did not add a wait");
	a_strobe_held_wait: assert property (hold |=> $stable(rd_q) && $stable(wr_q) &&
		$stable(addr_q))
		else $error("strobes changed during a wait-state");
	a_full_wait_seq: assert property (s_sel_wait_req ##1 s_wait_history_flag_cycle |-> active_q)
		else $error("transaction ended inside its wait");
	a_no_match_quiet: assert property (take && !(|hit) |=> rd_q == '0 && wr_q == '0 &&
		en_q == '0)
		else $error("selector asserted without match");
	a_read_on_match: assert property (take && BUS_REQ_IN.rd && hit[0] &&
		cfg_q[0].mode == BSAS_MODE_PLAIN |=> rd_q[0] && !wr_q[0])
		else $error("plain read strobe wrong");
	a_chip_enable_wr: assert property (take && BUS_REQ_IN.wr && hit[1] &&
		cfg_q[1].mode == BSAS_MODE_COMBINED_DECODE_MACRO |=> en_q[1] && !rd_q[1])
		else $error("chip select write decode wrong");
	a_mask_lock_hold: assert property (lock_q |=> $stable(zmask_q[0]) &&
		$stable(omask_q[0]))
		else $error("mask changed after lock");
	a_fabric_addr_full: assert property (take |=> addr_q == $past(BUS_REQ_IN.addr))
		else $error("fabric address not full width");
endmodule : bsas_socket

// ===== test/bsas_fabric_model.sv
`timescale 1ns/1ns
`include "bsas_params.svh"
module bsas_fabric_model
	import bsas_pkg::*;
#(
	parameter logic [`BSAS_NUM_SEL*8-1:0] VALUE = '0
)
(
	input wire logic clk_in,
	input wire logic [`BSAS_NUM_SEL-1:0] rd_strobe_in,
	input wire logic [1:0] chan_req_in,
	output logic [`BSAS_NUM_SEL*8-1:0] rdata_out,
	output logic [1:0] chan_ack_out
);
	// Unselected functions must give zeroes, else they corrupt the OR bus
	always_comb
	begin
		for (int i = 0; i < `BSAS_NUM_SEL; i++)
			rdata_out[i*8 +: 8] = rd_strobe_in[i] ? VALUE[i*8 +: 8] : 8'h00;
	end
	// Channels acknowledge one cycle after a request, no bus arbitration delay
	always_ff @(posedge clk_in)
		chan_ack_out <= chan_req_in;
endmodule : bsas_fabric_model

// ===== test/test_bus_socket_address_selector.sv
`timescale 1ns/1ns
`include "bsas_params.svh"
module test_bus_socket_address_selector
	import bsas_pkg::*;
;
	localparam int N = `BSAS_NUM_SEL;
	localparam logic [N*8-1:0] FAB_VAL = 32'h3c00a55a;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	bsas_req_t req;
	logic [7:0] brd;
	logic bwait;
	logic ext;
	logic hist;
	logic [N*8-1:0] frd;
	logic [31:0] faddr;
	logic [7:0] fwd;
	logic [N-1:0] rs;
	logic [N-1:0] ws;
	logic [N-1:0] de;
	logic [N-1:0] tk;
	logic [N-1:0] dreq;
	logic [N-1:0] dgr;
	logic [1:0] creq;
	logic [1:0] cack;
	int num_errors = 0;
	int total_checks = 0;
	// Selector setup: {APB address, data}; masks then control per selector
	logic [43:0] cfg [12] = '{
		{12'h100, 32'hffff_efff}, {12'h104, 32'h0000_100f}, {12'h108, 32'h04},
		{12'h110, 32'hffff_ff7a}, {12'h114, 32'h0000_0085}, {12'h118, 32'h09},
		{12'h120, 32'hffff_dfff}, {12'h124, 32'h0000_2000}, {12'h128, 32'h06},
		{12'h130, 32'hffff_cfff}, {12'h134, 32'h0000_3000}, {12'h138, 32'h14}};
	// Bus cycles: {addr, rd wr spec, wdata, rs ws de, wait, read data}
	logic [63:0] ops [11] = '{
		{32'h0000_1005, 3'b100, 8'h00, 12'h100, 1'b0, 8'h5a},
		{32'h0000_100f, 3'b010, 8'hc3, 12'h010, 1'b0, 8'h00},
		{32'h0000_1010, 3'b100, 8'h00, 12'h000, 1'b0, 8'h00},
		{32'h8000_1005, 3'b100, 8'h00, 12'h000, 1'b0, 8'h00},
		{32'h0000_1005, 3'b101, 8'h00, 12'h000, 1'b0, 8'h00},
		{32'h0000_0085, 3'b101, 8'h00, 12'h202, 1'b0, 8'ha5},
		{32'h0000_0085, 3'b011, 8'h5e, 12'h002, 1'b0, 8'h00},
		{32'h0000_0085, 3'b100, 8'h00, 12'h000, 1'b0, 8'h00},
		{32'h0000_3000, 3'b010, 8'h11, 12'h080, 1'b1, 8'h00},
		{32'h0000_2000, 3'b010, 8'h33, 12'h000, 1'b0, 8'h00},
		{32'h0000_2000, 3'b100, 8'h00, 12'h000, 1'b0, 8'h33}};

	bsas_socket i_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BUS_REQ_IN(req), .BUS_RDATA_OUT(brd),
		.BUS_WAIT_OUT(bwait), .FABRIC_RDATA_IN(frd), .EXTEND_NEXT_CYCLE_IN(ext),
		.WAIT_HISTORY_FLAG_OUT(hist), .FABRIC_ADDR_OUT(faddr), .FABRIC_WDATA_OUT(fwd),
		.READ_STROBE_OUT(rs), .WRITE_STROBE_OUT(ws), .DEVICE_ENABLE_OUT(de),
		.EXT_PORT_TAKE_OUT(tk), .DMA_REQUEST_IN(dreq), .DMA_GRANT_OUT(dgr),
		.DMA_CHAN_REQ_OUT(creq), .DMA_CHAN_ACK_IN(cack));
	bsas_fabric_model #(.VALUE(FAB_VAL)) i_fab (.clk_in(clk), .rd_strobe_in(rs),
		.chan_req_in(creq), .rdata_out(frd), .chan_ack_out(cack));

	// Free-running 10 MHz clock
	always #50 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	// One APB transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic e, input logic [31:0] x);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// A hung slave is ended by the watchdog, not here
		do
			@(posedge clk);
		while (pready !== 1'b1);
		check({pslverr, pready}, {e, 1'b1});
		if (!w)
			check(prdata, x);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	// One bus transfer; held through the selector wait when one is expected
	task automatic bus_op(input logic [63:0] e);
		req <= '{e[63:32], e[28:21], e[31], e[30], e[29]};
		@(posedge clk);
		if (!e[8])
			req <= '0;
		@(negedge clk);
		check({rs, ws, de}, e[20:9]);
		check(faddr, e[63:32]);
		check({fwd, bwait}, {e[28:21], e[8]});
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		check(brd, e[7:0]);
		@(posedge clk);
	endtask : bus_op

	// Main sequence
	initial
	begin
		req = '0;
		ext = 1'b0;
		dreq = '0;
		paddr = '0;
		pwdata = '0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({rs, ws, de, tk, dgr, creq, brd, hist, bwait}, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h108, '0, 1'b0, 32'h0);
		apb(1'b0, 12'h800, '0, 1'b1, 32'h0);
		foreach (cfg[i])
			apb(1'b1, cfg[i][43:32], cfg[i][31:0], 1'b0, 32'h0);
		apb(1'b0, 12'h138, '0, 1'b0, 32'h14);
		apb(1'b1, 12'h000, 32'h1, 1'b0, 32'h0);
		apb(1'b1, 12'h100, 32'h0, 1'b1, 32'h0);
		apb(1'b0, 12'h100, '0, 1'b0, 32'hffff_efff);
		check($bits(rs), 32'd4);
		foreach (ops[i])
			bus_op(ops[i]);
		apb(1'b0, 12'h12c, '0, 1'b0, 32'h7);
		// Two reads to different selectors with no idle cycle between
		req <= '{32'h0000_1001, 8'h00, 1'b1, 1'b0, 1'b0};
		@(posedge clk);
		req <= '{32'h0000_0085, 8'h00, 1'b1, 1'b0, 1'b1};
		@(negedge clk);
		check(rs, 4'b0001);
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		check({rs, brd}, {4'b0010, 8'h5a});
		@(negedge clk);
		check({rs, brd}, {4'b0000, 8'ha5});
		// Selector wait stretched once by the fabric, master holding throughout
		@(posedge clk);
		req <= '{32'h0000_3000, 8'h00, 1'b1, 1'b0, 1'b0};
		@(posedge clk);
		ext <= 1'b1;
		@(negedge clk);
		check({rs, bwait, hist}, {4'b1000, 2'b10});
		@(posedge clk);
		ext <= 1'b0;
		@(negedge clk);
		check({rs, bwait, hist}, {4'b1000, 2'b11});
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		check({rs, bwait, hist}, {4'b1000, 2'b01});
		@(negedge clk);
		check({rs, bwait, hist, brd}, {4'b0000, 2'b00, 8'h3c});
		// Steered request and returned grant, then blocked once disabled
		@(posedge clk);
		dreq <= 4'b0100;
		@(posedge clk);
		@(negedge clk);
		check(creq, 2'b10);
		repeat (2) @(negedge clk);
		check(dgr, 4'b0100);
		@(posedge clk);
		bus_op({32'h0000_2000, 3'b010, 8'h22, 12'h000, 1'b0, 8'h00});
		@(negedge clk);
		check({dgr, creq}, 6'h00);
		@(posedge clk);
		dreq <= '0;
		// External port mode only claims the transfer, no strobe
		apb(1'b1, 12'h108, 32'h07, 1'b0, 32'h0);
		req <= '{32'h0000_1005, 8'h00, 1'b1, 1'b0, 1'b0};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		check({tk, rs, de}, {4'b0001, 8'h00});
		@(posedge clk);
		print_verdict();
	end

	// Watchdog well beyond the roughly 150 cycles the sequence needs
	initial
	begin
		#(100 * 3000);
		num_errors++;
		print_verdict();
	end
endmodule : test_bus_socket_address_selector
